// File: bench/xic_pin_model.sv
`timescale 1ns/1ps
module xic_pin_model (
    // Source pulls: bit 1 channel 2 pin, bit 0 channel 3 pin
    input  wire logic [1:0] pull_low_i,
    // Device drive
    input  wire logic [3:0] drive_oe_b_i,
    input  wire logic [3:0] drive_val_i,
    // Pulled-up pins, any driver wins low
    output logic      [3:0] pin_o
);
    assign pin_o = (drive_oe_b_i | drive_val_i) & ~{pull_low_i, 2'b00};
endmodule

// File: bench/xic_top_assertions.sv
`timescale 1ns/1ps
module xic_top_assertions
    import xic_pkg::*;
(
    // Watched ports
    input wire logic       sys_clk_i,
    input wire logic       rst_b_i,
    input wire xic_op_e    sfr_op_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       vector_ch2_i,
    input wire logic       irq_req_ch2_o,
    input wire logic       priority_high_ch3_o,
    input wire logic [3:0] extra_nibble_port_i,
    input wire logic [3:0] extra_nibble_port_oe_b_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    xic_op_e    o;
    logic [7:0] a;
    assign o = sfr_op_i;
    assign a = sfr_addr_i;
    property p_rd_idle; !$past(sfr_rd_i) |-> sfr_rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata without read");
    property p_ctrl_rb; o == XIC_OP_WRITE && a == 8'hc0 ##1 sfr_rd_i && a == 8'hc0
        |=> (sfr_rdata_o & 8'hdd) == ($past(sfr_wdata_i, 2) & 8'hdd); endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback");
    property p_en_clr; o == XIC_OP_CLRB && a == 8'hc2 |=> ##1 !irq_req_ch2_o; endproperty
    a_en_clr: assert property (p_en_clr) else $error("request while off");
    property p_pri_set; o == XIC_OP_SETB && a == 8'hc7 |=> ##1 priority_high_ch3_o; endproperty
    a_pri_set: assert property (p_pri_set) else $error("priority not set");
    property p_pri_clr; o == XIC_OP_CLRB && a == 8'hc7 |=> ##1 !priority_high_ch3_o; endproperty
    a_pri_clr: assert property (p_pri_clr) else $error("priority not clear");
    // Pin held high so no fresh edge can win over the clear
    property p_vec_clr; extra_nibble_port_i[3] [*4] ##0 vector_ch2_i |=> ##1 !irq_req_ch2_o;
    endproperty
    a_vec_clr: assert property (p_vec_clr) else $error("vector left request");
    property p_reset; $rose(rst_b_i) |-> extra_nibble_port_oe_b_o == 4'hf
        && !priority_high_ch3_o && !irq_req_ch2_o; endproperty
    a_reset: assert property (p_reset) else $error("reset state");
    property p_port_wr; o == XIC_OP_WRITE && a == 8'hc8
        |=> extra_nibble_port_oe_b_o == $past(sfr_wdata_i[3:0]); endproperty
    a_port_wr: assert property (p_port_wr) else $error("port latch");
    c_edge_req: cover property ($rose(irq_req_ch2_o));
    c_vec_req: cover property (vector_ch2_i && irq_req_ch2_o);
    c_pri3: cover property ($rose(priority_high_ch3_o));
endmodule

bind xic_top xic_top_assertions chk_u (.*);

// File: bench/xic_top_tb.sv
`timescale 1ns/1ps
module xic_top_tb
    import xic_pkg::*;
;
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] addr;
        logic [7:0] wd;
        logic [7:0] exp;
    } xic_row_s;
    xic_row_s rows [13] = '{'{2'h1, 8'hc0, 8'hff, 8'hdd}, '{2'h3, 8'hc0, 8'h00, 8'hdc},
        '{2'h3, 8'hc2, 8'h00, 8'hd8}, '{2'h3, 8'hc3, 8'h00, 8'hd0}, '{2'h3, 8'hc4, 8'h00, 8'hc0},
        '{2'h3, 8'hc6, 8'h00, 8'h80}, '{2'h3, 8'hc7, 8'h00, 8'h00}, '{2'h2, 8'hc2, 8'h00, 8'h04},
        '{2'h2, 8'hc1, 8'h00, 8'h04}, '{2'h1, 8'h90, 8'h55, 8'h00}, '{2'h1, 8'hc8, 8'h05, 8'h05},
        '{2'h2, 8'hcb, 8'h00, 8'h0d}, '{2'h1, 8'hc8, 8'h0f, 8'h0f}};
    logic            sys_clk_i = 1'b0;
    logic            rst_b_i = 1'b0;
    xic_op_e         sfr_op_i = XIC_OP_NONE;
    logic      [7:0] sfr_addr_i = 8'h00;
    logic      [7:0] sfr_wdata_i = 8'h00;
    logic            sfr_rd_i = 1'b0;
    logic            vector_ch2_i = 1'b0;
    logic            vector_ch3_i = 1'b0;
    logic      [1:0] pull_low = 2'h0;
    logic      [7:0] sfr_rdata_o, q;
    logic            irq_req_ch2_o, irq_req_ch3_o, priority_high_ch2_o, priority_high_ch3_o;
    logic      [3:0] extra_nibble_port_i, extra_nibble_port_o, extra_nibble_port_oe_b_o;
    int              n_mismatch = 0, n_compared = 0, cyc = 0;
    xic_top dut_u (.*);
    xic_pin_model pin_u (.pull_low_i(pull_low), .drive_oe_b_i(extra_nibble_port_oe_b_o),
        .drive_val_i(extra_nibble_port_o), .pin_o(extra_nibble_port_i));
    always #5 sys_clk_i = ~sys_clk_i;
    task automatic idle(int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic op(xic_op_e o, logic [7:0] a, logic [7:0] d);
        @(negedge sys_clk_i);
        sfr_op_i = o;
        sfr_addr_i = a;
        sfr_wdata_i = d;
        @(negedge sys_clk_i);
        sfr_op_i = XIC_OP_NONE;
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        sfr_rd_i = 1'b1;
        sfr_addr_i = a;
        @(negedge sys_clk_i);
        sfr_rd_i = 1'b0;
        d = sfr_rdata_o;
    endtask
    task automatic chk(string s, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Whole run needs about 115 cycles
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        idle(12);
        rst_b_i = 1'b1;
        foreach (rows[i]) begin
            op(xic_op_e'(rows[i].op), rows[i].addr, rows[i].wd);
            if (rows[i].addr[7:3] == 5'h19) idle(4);
            rd({rows[i].addr[7:3], 3'h0}, q);
            chk("row read", rows[i].exp, q);
        end
        // One-cycle low pulse: only a latched edge survives it
        op(XIC_OP_WRITE, 8'hc0, 8'h05);
        pull_low = 2'b10;
        idle(1);
        pull_low = 2'b00;
        idle(6);
        chk("edge req2", 8'h01, {7'h0, irq_req_ch2_o});
        rd(8'hc0, q);
        chk("edge flag", 8'h07, q);
        vector_ch2_i = 1'b1;
        idle(1);
        vector_ch2_i = 1'b0;
        idle(2);
        chk("vector req2", 8'h00, {7'h0, irq_req_ch2_o});
        op(XIC_OP_WRITE, 8'hc0, 8'h40);
        pull_low = 2'b01;
        idle(6);
        chk("level req3", 8'h01, {7'h0, irq_req_ch3_o});
        rd(8'hc0, q);
        chk("level flag", 8'h60, q);
        pull_low = 2'b00;
        idle(6);
        chk("level end", 8'h00, {7'h0, irq_req_ch3_o});
        // Channel 3 edge path, channel 2 raised to high priority
        op(XIC_OP_WRITE, 8'hc0, 8'h58);
        pull_low = 2'b01;
        idle(1);
        pull_low = 2'b00;
        idle(6);
        chk("edge req3", 8'h01, {7'h0, irq_req_ch3_o});
        chk("pri2", 8'h01, {7'h0, priority_high_ch2_o});
        vector_ch3_i = 1'b1;
        idle(1);
        vector_ch3_i = 1'b0;
        idle(2);
        chk("vector req3", 8'h00, {7'h0, irq_req_ch3_o});
        pull_low = 2'b01;
        op(XIC_OP_CLRB, 8'hc6, 8'h00);
        op(XIC_OP_SETB, 8'hc7, 8'h00);
        idle(4);
        chk("gated req3", 8'h00, {7'h0, irq_req_ch3_o});
        chk("pri3", 8'h01, {7'h0, priority_high_ch3_o});
        pull_low = 2'b00;
        rst_b_i = 1'b0;
        idle(2);
        chk("reset outs", 8'h0f, {priority_high_ch2_o, priority_high_ch3_o, irq_req_ch2_o,
            irq_req_ch3_o, extra_nibble_port_oe_b_o});
        rst_b_i = 1'b1;
        rd(8'hc0, q);
        chk("reset ctrl", 8'h00, q);
        print_verdict();
    end
endmodule

// File: rtl/xic_chan.sv
`timescale 1ns/1ps
`include "xic_defines.svh"
module xic_chan
    import xic_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    // Channel link
    xic_chan_if.chan  ch
);
    xic_chan_s st;
    xic_chan_s next_st;

    always_comb begin
        next_st             = st;
        next_st.edge_select = ch.edge_select;
        next_st.pin_prev    = ch.pin_sync;
        if (ch.edge_select) begin
            // Edge wins over a same-cycle vector clear
            if (st.pin_prev && !ch.pin_sync) begin
                next_st.pending = 1'b1;
            end else if (ch.vector_ack) begin
                next_st.pending = 1'b0;
            end
        end else begin
            next_st.pending = !ch.pin_sync;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '{edge_select: 1'b0, pin_prev: 1'b1, pending: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign ch.pending = st.pending;
endmodule

// File: rtl/xic_chan_if.sv
`timescale 1ns/1ps
interface xic_chan_if;
    logic pin_sync;
    logic edge_select;
    logic vector_ack;
    logic pending;

    modport owner (output pin_sync, output edge_select, output vector_ack, input pending);
    modport chan  (input pin_sync, input edge_select, input vector_ack, output pending);
endinterface

// File: rtl/xic_defines.svh
`ifndef XIC_DEFINES_SVH
`define XIC_DEFINES_SVH

// Special-function byte addresses
`define XIC_CTRL_ADDR     8'hc0
`define XIC_PORT_ADDR     8'hc8
// Bit address of each control bit is base plus bit index
`define XIC_CTRL_BIT_BASE 8'hc0
`define XIC_PORT_BIT_BASE 8'hc8
// Control register field positions
`define XIC_IT2_POS       3'h0
`define XIC_IE2_POS       3'h1
`define XIC_EX2_POS       3'h2
`define XIC_PX2_POS       3'h3
`define XIC_IT3_POS       3'h4
`define XIC_IE3_POS       3'h5
`define XIC_EX3_POS       3'h6
`define XIC_PX3_POS       3'h7
// Port pin carrying each channel input
`define XIC_CH2_PIN       2'h3
`define XIC_CH3_PIN       2'h2
// Reset values
`define XIC_CTRL_RESET    8'h00
`define XIC_PORT_RESET    4'hf

`endif

// File: rtl/xic_pkg.sv
package xic_pkg;
    typedef enum logic [1:0] {
        XIC_OP_NONE  = 2'b00,
        XIC_OP_WRITE = 2'b01,
        XIC_OP_SETB  = 2'b10,
        XIC_OP_CLRB  = 2'b11
    } xic_op_e;

    typedef struct packed {
        logic       edge_select;
        logic       pin_prev;
        logic       pending;
    } xic_chan_s;
endpackage

// File: rtl/xic_top.sv
`timescale 1ns/1ps
`include "xic_defines.svh"
// Behaviour
// - Control register sits at C0H; every bit except the pending bits 1 and 5 set/clearable by bit instructions.
// - Bit address C2H is the channel-2 enable bit.
// - Priority bit set puts channel at high level, clear at low.
// - Request reaches the core only while the channel enable is set.
// - Edge select 1 detects falling edge; 0 detects low level.
// - Edge mode: edge sets pending, vectoring to the routine clears it.
// - Channels 2 and 3 behave like standard external interrupts 0 and 1.
// - Channel inputs are alternate functions of port bits 3 and 2.
// - Extra port is four bidirectional bit-addressable bits.
// - Reset clears the control register to zero.
module xic_top
    import xic_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    // Special-function access from the core
    input  wire xic_op_e    sfr_op_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_rd_i,
    output logic      [7:0] sfr_rdata_o,
    // Core interrupt controller
    input  wire logic       vector_ch2_i,
    input  wire logic       vector_ch3_i,
    output logic            irq_req_ch2_o,
    output logic            irq_req_ch3_o,
    output logic            priority_high_ch2_o,
    output logic            priority_high_ch3_o,
    // Extra nibble port pins
    input  wire logic [3:0] extra_nibble_port_i,
    output logic      [3:0] extra_nibble_port_o,
    output logic      [3:0] extra_nibble_port_oe_b_o
);
    typedef struct packed {
        logic [3:0] pin_meta;
        logic [3:0] pin_sync;
        logic [7:0] ctrl;
        logic [3:0] latch;
        logic [7:0] rdata;
        logic       req2;
        logic       req3;
        logic       pri2;
        logic       pri3;
    } xic_top_s;

    xic_top_s st;
    xic_top_s next_st;

    xic_chan_if ch2_if ();
    xic_chan_if ch3_if ();

    // Channel inputs taken from the synchronised port pins
    assign ch2_if.pin_sync    = st.pin_sync[`XIC_CH2_PIN];
    assign ch3_if.pin_sync    = st.pin_sync[`XIC_CH3_PIN];
    assign ch2_if.edge_select = st.ctrl[`XIC_IT2_POS];
    assign ch3_if.edge_select = st.ctrl[`XIC_IT3_POS];
    assign ch2_if.vector_ack  = vector_ch2_i;
    assign ch3_if.vector_ack  = vector_ch3_i;

    // Same engine as the standard external interrupts
    xic_chan u_ch2 (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .ch        (ch2_if.chan)
    );

    xic_chan u_ch3 (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .ch        (ch3_if.chan)
    );

    logic       ctrl_bit_hit;
    logic       port_bit_hit;
    logic [2:0] bit_idx;

    always_comb begin
        bit_idx      = sfr_addr_i[2:0];
        ctrl_bit_hit = (sfr_addr_i[7:3] == 5'(`XIC_CTRL_BIT_BASE >> 3));
        port_bit_hit = (sfr_addr_i[7:3] == 5'(`XIC_PORT_BIT_BASE >> 3)) && !sfr_addr_i[2];
    end

    always_comb begin
        next_st          = st;
        next_st.pin_meta = extra_nibble_port_i;
        next_st.pin_sync = st.pin_meta;

        // Pending bits mirror the channel engines
        next_st.ctrl[`XIC_IE2_POS] = ch2_if.pending;
        next_st.ctrl[`XIC_IE3_POS] = ch3_if.pending;

        unique case (sfr_op_i)
            XIC_OP_NONE: begin
            end
            XIC_OP_WRITE: begin
                if (sfr_addr_i == `XIC_CTRL_ADDR) begin
                    next_st.ctrl = sfr_wdata_i;
                    // Pending is hardware owned; software writes are ignored
                    next_st.ctrl[`XIC_IE2_POS] = ch2_if.pending;
                    next_st.ctrl[`XIC_IE3_POS] = ch3_if.pending;
                end else if (sfr_addr_i == `XIC_PORT_ADDR) begin
                    next_st.latch = sfr_wdata_i[3:0];
                end
            end
            XIC_OP_SETB, XIC_OP_CLRB: begin
                // Bit C2H lands on the channel-2 enable
                if (ctrl_bit_hit && bit_idx != `XIC_IE2_POS && bit_idx != `XIC_IE3_POS) begin
                    next_st.ctrl[bit_idx] = (sfr_op_i == XIC_OP_SETB);
                end else if (port_bit_hit) begin
                    next_st.latch[bit_idx[1:0]] = (sfr_op_i == XIC_OP_SETB);
                end
            end
        endcase

        // Registered read data
        next_st.rdata = 8'h00;
        if (sfr_rd_i) begin
            if (sfr_addr_i == `XIC_CTRL_ADDR) begin
                next_st.rdata = st.ctrl;
            end else if (sfr_addr_i == `XIC_PORT_ADDR) begin
                next_st.rdata = {4'h0, st.pin_sync};
            end
        end

        next_st.req2 = ch2_if.pending && st.ctrl[`XIC_EX2_POS];
        next_st.req3 = ch3_if.pending && st.ctrl[`XIC_EX3_POS];
        next_st.pri2 = st.ctrl[`XIC_PX2_POS];
        next_st.pri3 = st.ctrl[`XIC_PX3_POS];
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st.pin_meta <= 4'hf;
            st.pin_sync <= 4'hf;
            st.ctrl     <= `XIC_CTRL_RESET;
            st.latch    <= `XIC_PORT_RESET;
            st.rdata    <= 8'h00;
            st.req2     <= 1'b0;
            st.req3     <= 1'b0;
            st.pri2     <= 1'b0;
            st.pri3     <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Quasi-bidirectional: drive low only, latch 1 releases the pin as input
    logic [3:0] oe_b;
    always_comb begin
        oe_b = st.latch;
    end

    assign sfr_rdata_o              = st.rdata;
    assign irq_req_ch2_o            = st.req2;
    assign irq_req_ch3_o            = st.req3;
    assign priority_high_ch2_o      = st.pri2;
    assign priority_high_ch3_o      = st.pri3;
    assign extra_nibble_port_o      = 4'h0;
    assign extra_nibble_port_oe_b_o = oe_b;
endmodule
